/* logic/lic_consts.vh */
// Purpose: constants for the line interface control and status block
// Assumes: 10 MHz mclk, synchronous active-high reset
// Notes:   offsets are byte offsets on an 8-bit register port
//
// Summary of operation
// - Alarm bit 0 sends unframed all ones; 1 sends data normally.
// - Rising insert bit waits for two ones, then inserts one violation on the third one.
// - Next violation needs clear then set; none in composite-clock or 6312kHz modes.
// - Rising reset bit resets clock recovery and recentres jitter FIFO.
// - Bit 7 enables 12.8-to-2.048MHz PLL; selects jitter clock source.
// - Alternate-pattern bit drives continuous one-zero pattern on line outputs.
// - Monitor gain field picks boost: none, 20, 26 or 32 dB.
// - CMI invert bit flips CMI polarity at transmit and receive tip.
// - Receive termination: off, 75, 100, 120, 110 ohm; codes 101-111 off.
// - Transmit termination uses the same decode as receive termination.
// - Four-bit real-time receive level in 2.5 dB steps; upper bits zero.
// - Open-circuit status follows detector; absent in 6312kHz mode.
// - Current-limit status follows limiter; absent in CMI, 64kHz, 6312kHz.
// - Jitter trip bit latches near FIFO limit, clears on status read.
// - Unmasked open-circuit or current-limit interrupts on both edges.
// - Mask bit 4 gates the jitter trip interrupt.
// - Low clock-select bit enables 2.048-to-1.544MHz PLL, else bypassed.
`ifndef LIC_CONSTS_VH
`define LIC_CONSTS_VH

// ==========================================================
// Register offsets
`define LIC_OFS_RX_LEVEL   8'h11
`define LIC_OFS_STATUS     8'h14
`define LIC_OFS_MASK       8'h15
`define LIC_OFS_CTRL_B     8'h31
`define LIC_OFS_CTRL_C     8'h32
`define LIC_OFS_CTRL_D     8'h33

// ==========================================================
// Reset value
`define LIC_RST_VAL        8'h00

// ==========================================================
// Control b fields
`define LIC_B_CLK_SEL_LO   3
`define LIC_B_ALARM_N      4
`define LIC_B_INJECT       5
`define LIC_B_SOFT_RST     6
`define LIC_B_CLK_SEL_HI   7

// ==========================================================
// Control c fields
`define LIC_C_ALT_PAT      0
`define LIC_C_GAIN_LO      3
`define LIC_C_CMI_FLIP     6
`define LIC_C_CMI_ON       7
`define LIC_C_WMASK        8'hD9

// ==========================================================
// Control d fields
`define LIC_D_RX_TERM_LO   0
`define LIC_D_TX_TERM_LO   3
`define LIC_D_PRESCALE_LO  6

// ==========================================================
// Status and mask fields
`define LIC_S_OPEN         1
`define LIC_S_CURLIM       2
`define LIC_S_JA_TRIP      4
`define LIC_S_WMASK        8'h16

// ==========================================================
// Transmit modes and terminations
`define LIC_MODE_NORMAL    2'h0
`define LIC_MODE_COMPOSITE 2'h1
`define LIC_MODE_6312K     2'h2
`define LIC_TERM_OFF       3'h0
`define LIC_TERM_MAX       3'h4

// ==========================================================
// Soft reset pulse length
`define LIC_SOFT_RST_NS    200
`define LIC_CLK_NS         100
`define LIC_SOFT_RST_CYC   ((`LIC_SOFT_RST_NS + `LIC_CLK_NS - 1) / `LIC_CLK_NS)

`endif

/* logic/lic_line_if_regs.v */
// Purpose: line interface control and status registers
// Assumes: 8-bit register port, read data one cycle after read strobe
// Notes:   analog detectors arrive as synchronous levels
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lic_consts.vh"
module lic_line_if_regs (
  input  wire       mclk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_r,
  input  wire [1:0] tx_mode,
  input  wire       tx_bit_en,
  input  wire       tx_data,
  input  wire [3:0] rx_level_in,
  input  wire       tx_open_in,
  input  wire       tx_curlim_in,
  input  wire       ja_near_limit,
  output wire       tx_line_bit,
  output wire       tx_line_bpv,
  output reg        cmi_coding_on_r,
  output reg        cmi_polarity_flip_r,
  output reg  [1:0] monitor_gain_r,
  output reg  [2:0] rx_term_r,
  output reg  [2:0] tx_term_r,
  output reg  [1:0] master_clk_prescale_r,
  output reg        ja_clk_sel_hi_r,
  output reg        ja_clk_sel_lo_r,
  output reg        line_if_soft_reset_r,
  output reg        irq_n_r
);

  reg  [7:0] ctrl_b_r;
  reg  [7:0] ctrl_c_r;
  reg  [7:0] ctrl_d_r;
  reg  [7:0] mask_r;
  reg  [3:0] rx_level_r;
  reg        open_r;
  reg        curlim_r;
  reg        ja_trip_r;
  reg        open_evt_r;
  reg        curlim_evt_r;
  reg        soft_d_r;
  reg  [1:0] soft_cnt_r;
  reg  [7:0] rdata_nxt;
  wire [7:0] status_w;
  wire       open_cond;
  wire       curlim_cond;
  wire       status_rd;
  wire       wr_b;
  wire       wr_c;
  wire       wr_d;
  wire       wr_m;

  localparam [31:0] SOFT_CYC = `LIC_SOFT_RST_CYC;

  // ==========================================================
  // Decode helpers
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function [2:0] term_dec;
    input [2:0] code;
    begin
      if (code > `LIC_TERM_MAX)
        term_dec = `LIC_TERM_OFF;
      else
        term_dec = code;
    end
  endfunction

  assign wr_b      = reg_wr && hit(reg_addr, `LIC_OFS_CTRL_B);
  assign wr_c      = reg_wr && hit(reg_addr, `LIC_OFS_CTRL_C);
  assign wr_d      = reg_wr && hit(reg_addr, `LIC_OFS_CTRL_D);
  assign wr_m      = reg_wr && hit(reg_addr, `LIC_OFS_MASK);
  assign status_rd = reg_rd && hit(reg_addr, `LIC_OFS_STATUS);

  // Detectors gated off in modes where they are not provided
  assign open_cond   = tx_open_in && tx_mode != `LIC_MODE_6312K;
  assign curlim_cond = tx_curlim_in && tx_mode == `LIC_MODE_NORMAL &&
                       !ctrl_c_r[`LIC_C_CMI_ON];

  assign status_w = {3'h0, ja_trip_r, 1'b0, curlim_r, open_r, 1'b0};

  // ==========================================================
  // Control registers; unused bits of control c and mask forced to zero, control b stored as written
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_b_r <= `LIC_RST_VAL;
      ctrl_c_r <= `LIC_RST_VAL;
      ctrl_d_r <= `LIC_RST_VAL;
      mask_r   <= `LIC_RST_VAL;
    end else begin
      if (wr_b)
        ctrl_b_r <= reg_wdata;
      if (wr_c)
        ctrl_c_r <= reg_wdata & `LIC_C_WMASK;
      if (wr_d)
        ctrl_d_r <= reg_wdata;
      if (wr_m)
        mask_r <= reg_wdata & `LIC_S_WMASK;
    end
  end

  // ==========================================================
  // Control outputs
  always @(posedge mclk) begin
    if (rst) begin
      cmi_coding_on_r       <= 1'b0;
      cmi_polarity_flip_r   <= 1'b0;
      monitor_gain_r        <= 2'h0;
      rx_term_r             <= 3'h0;
      tx_term_r             <= 3'h0;
      master_clk_prescale_r <= 2'h0;
      ja_clk_sel_hi_r       <= 1'b0;
      ja_clk_sel_lo_r       <= 1'b0;
    end else begin
      cmi_coding_on_r       <= ctrl_c_r[`LIC_C_CMI_ON];
      cmi_polarity_flip_r   <= ctrl_c_r[`LIC_C_CMI_FLIP];
      monitor_gain_r        <= ctrl_c_r[`LIC_C_GAIN_LO +: 2];
      rx_term_r             <= term_dec(ctrl_d_r[`LIC_D_RX_TERM_LO +: 3]);
      tx_term_r             <= term_dec(ctrl_d_r[`LIC_D_TX_TERM_LO +: 3]);
      master_clk_prescale_r <= ctrl_d_r[`LIC_D_PRESCALE_LO +: 2];
      ja_clk_sel_hi_r       <= ctrl_b_r[`LIC_B_CLK_SEL_HI];
      ja_clk_sel_lo_r       <= ctrl_b_r[`LIC_B_CLK_SEL_LO];
    end
  end

  // ==========================================================
  // Soft reset pulse on rising edge of the reset bit
  always @(posedge mclk) begin
    if (rst) begin
      soft_d_r             <= 1'b0;
      soft_cnt_r           <= 2'h0;
      line_if_soft_reset_r <= 1'b0;
    end else begin
      soft_d_r <= ctrl_b_r[`LIC_B_SOFT_RST];
      if (ctrl_b_r[`LIC_B_SOFT_RST] && !soft_d_r) begin
        soft_cnt_r           <= SOFT_CYC[1:0];
        line_if_soft_reset_r <= 1'b1;
      end else if (soft_cnt_r != 2'h0) begin
        soft_cnt_r           <= soft_cnt_r - 2'h1;
        line_if_soft_reset_r <= (soft_cnt_r != 2'h1);
      end else
        line_if_soft_reset_r <= 1'b0;
    end
  end

  // ==========================================================
  // Status and edge events; set wins over clear by read
  always @(posedge mclk) begin
    if (rst) begin
      rx_level_r   <= 4'h0;
      open_r       <= 1'b0;
      curlim_r     <= 1'b0;
      ja_trip_r    <= 1'b0;
      open_evt_r   <= 1'b0;
      curlim_evt_r <= 1'b0;
    end else begin
      rx_level_r <= rx_level_in;
      open_r     <= open_cond;
      curlim_r   <= curlim_cond;
      if (open_cond != open_r)
        open_evt_r <= 1'b1;
      else if (status_rd)
        open_evt_r <= 1'b0;
      if (curlim_cond != curlim_r)
        curlim_evt_r <= 1'b1;
      else if (status_rd)
        curlim_evt_r <= 1'b0;
      if (ja_near_limit)
        ja_trip_r <= 1'b1;
      else if (status_rd)
        ja_trip_r <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt request, active low
  always @(posedge mclk) begin
    if (rst)
      irq_n_r <= 1'b1;
    else
      irq_n_r <= ~((open_evt_r   && mask_r[`LIC_S_OPEN])   ||
                   (curlim_evt_r && mask_r[`LIC_S_CURLIM]) ||
                   (ja_trip_r    && mask_r[`LIC_S_JA_TRIP]));
  end

  // ==========================================================
  // Read path; unmapped addresses read zero
  always @* begin
    if (hit(reg_addr, `LIC_OFS_RX_LEVEL))
      rdata_nxt = {4'h0, rx_level_r};
    else if (hit(reg_addr, `LIC_OFS_STATUS))
      rdata_nxt = status_w;
    else if (hit(reg_addr, `LIC_OFS_MASK))
      rdata_nxt = mask_r;
    else if (hit(reg_addr, `LIC_OFS_CTRL_B))
      rdata_nxt = ctrl_b_r;
    else if (hit(reg_addr, `LIC_OFS_CTRL_C))
      rdata_nxt = ctrl_c_r;
    else if (hit(reg_addr, `LIC_OFS_CTRL_D))
      rdata_nxt = ctrl_d_r;
    else
      rdata_nxt = 8'h00;
  end

  always @(posedge mclk) begin
    if (rst)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
      reg_rdata_r <= rdata_nxt;
    else
      reg_rdata_r <= 8'h00;
  end

  // ==========================================================
  // Transmit shaper; outputs are its flip-flops
  lic_tx_shaper u_shaper (
    .mclk             (mclk),
    .rst              (rst),
    .tx_bit_en        (tx_bit_en),
    .tx_data          (tx_data),
    .alarm_ones_n     (ctrl_b_r[`LIC_B_ALARM_N]),
    .alt_pattern      (ctrl_c_r[`LIC_C_ALT_PAT]),
    .inject_violation (ctrl_b_r[`LIC_B_INJECT]),
    .tx_mode          (tx_mode),
    .line_bit_r       (tx_line_bit),
    .line_bpv_r       (tx_line_bpv)
  );

endmodule // lic_line_if_regs
`default_nettype wire

/* logic/lic_tx_shaper.v */
// Purpose: transmit bit shaper with alarm, pattern and violation insert
// Assumes: one transmit bit per cycle while tx_bit_en is high
// Notes:   emits bit and a violation flag; the analog driver forms the pulses
`timescale 1ns/1ps
`default_nettype none
`include "lic_consts.vh"
module lic_tx_shaper (
  input  wire       mclk,
  input  wire       rst,
  input  wire       tx_bit_en,
  input  wire       tx_data,
  input  wire       alarm_ones_n,
  input  wire       alt_pattern,
  input  wire       inject_violation,
  input  wire [1:0] tx_mode,
  output reg        line_bit_r,
  output reg        line_bpv_r
);

  reg       inject_d_r;
  reg       armed_r;
  reg       alt_r;
  reg [1:0] ones_r;
  reg       bit_nxt;

  // ==========================================================
  // Source select
  always @* begin
    if (alt_pattern)
      bit_nxt = alt_r;
    else if (!alarm_ones_n)
      bit_nxt = 1'b1;
    else
      bit_nxt = tx_data;
  end

  // ==========================================================
  // Violation arming; only an edge arms, so holding the bit set gives one
  always @(posedge mclk) begin
    if (rst) begin
      inject_d_r <= 1'b0;
      armed_r    <= 1'b0;
      alt_r      <= 1'b0;
      ones_r     <= 2'h0;
      line_bit_r <= 1'b0;
      line_bpv_r <= 1'b0;
    end else begin
      inject_d_r <= inject_violation;
      if (inject_violation && !inject_d_r &&
          tx_mode == `LIC_MODE_NORMAL)
        armed_r <= 1'b1;
      else if (tx_mode != `LIC_MODE_NORMAL)
        armed_r <= 1'b0;
      line_bpv_r <= 1'b0;
      if (tx_bit_en) begin
        alt_r      <= ~alt_r;
        line_bit_r <= bit_nxt;
        if (bit_nxt) begin
          // Mode gate here too: a mode change after arming must not leak one
          if (ones_r == 2'h2 && armed_r &&
              tx_mode == `LIC_MODE_NORMAL) begin
            line_bpv_r <= 1'b1;
            armed_r    <= 1'b0;
            ones_r     <= 2'h0;
          end else if (ones_r != 2'h2)
            ones_r <= ones_r + 2'h1;
        end else
          ones_r <= 2'h0;
      end
    end
  end

endmodule // lic_tx_shaper
`default_nettype wire

/* test/lic_line_if_regs_properties.sv */
// Purpose: port checker for the line interface registers
// Assumes: one clock, synchronous active-high reset
// Notes:   decode checks skip writes followed by another write
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module lic_regs_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic [1:0] tx_mode,
  input wire logic       tx_bit_en,
  input wire logic [3:0] rx_level_in,
  input wire logic       tx_open_in,
  input wire logic       tx_line_bit,
  input wire logic       tx_line_bpv,
  input wire logic [1:0] monitor_gain_r,
  input wire logic [2:0] rx_term_r,
  input wire logic [2:0] tx_term_r,
  input wire logic       line_if_soft_reset_r,
  input wire logic       irq_n_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  function automatic logic [2:0] dec(input logic [2:0] c);
    dec = (c > 3'h4) ? 3'h0 : c;
  endfunction
  chk_level_read: assert property (
    reg_rd && reg_addr == 8'h11 && $stable(rx_level_in)
    |=> reg_rdata_r == {4'h0, $past(rx_level_in)}) else $error("level read wrong");
  chk_rx_term: assert property (
    reg_wr && reg_addr == 8'h33 ##1 !reg_wr
    |-> ##1 rx_term_r == dec($past(reg_wdata[2:0], 2))) else $error("rx term wrong");
  chk_tx_term: assert property (
    reg_wr && reg_addr == 8'h33 ##1 !reg_wr
    |-> ##1 tx_term_r == dec($past(reg_wdata[5:3], 2))) else $error("tx term wrong");
  chk_gain_sel: assert property (
    reg_wr && reg_addr == 8'h32 ##1 !reg_wr
    |-> ##1 monitor_gain_r == $past(reg_wdata[4:3], 2)) else $error("gain wrong");
  chk_soft_pulse: assert property (
    $rose(line_if_soft_reset_r) |=> line_if_soft_reset_r ##1 !line_if_soft_reset_r)
    else $error("soft reset pulse length wrong");
  chk_bpv_single: assert property (
    tx_line_bpv |-> tx_line_bit && $past(tx_bit_en) ##1 !tx_line_bpv)
    else $error("violation pulse wrong");
  chk_bpv_mode: assert property (
    tx_mode != 2'h0 |=> !tx_line_bpv) else $error("violation in other mode");
  chk_open_stat: assert property (
    reg_rd && reg_addr == 8'h14 && tx_open_in && $past(tx_open_in)
    |=> reg_rdata_r[1] == ($past(tx_mode, 2) != 2'h2)) else $error("open status wrong");
  chk_reset_vals: assert property (
    $fell(rst) |-> irq_n_r && rx_term_r == 3'h0 && monitor_gain_r == 2'h0)
    else $error("reset values wrong");
endmodule // lic_regs_chk
bind lic_line_if_regs lic_regs_chk u_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .tx_mode(tx_mode),
  .tx_bit_en(tx_bit_en), .rx_level_in(rx_level_in), .tx_open_in(tx_open_in),
  .tx_line_bit(tx_line_bit), .tx_line_bpv(tx_line_bpv), .monitor_gain_r(monitor_gain_r),
  .rx_term_r(rx_term_r), .tx_term_r(tx_term_r),
  .line_if_soft_reset_r(line_if_soft_reset_r), .irq_n_r(irq_n_r));
`default_nettype wire

/* test/lic_line_if_regs_tb.sv */
// Purpose: self-checking bench for the line interface registers
// Assumes: 10 MHz mclk, read data in the cycle after the strobe
// Notes:   tests share state; order matters
`timescale 1ns/1ps
`default_nettype none
`include "lic_consts.vh"
// ==========================================================
// Bench
module lic_line_if_regs_tb;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       ten = 1'b0;
  logic       tdat = 1'b0;
  logic       open_q = 1'b0;
  logic       lim_q = 1'b0;
  logic       trip_q = 1'b0;
  logic [3:0] lvl_q = 4'h0;
  logic [7:0] offs [7] = '{8'h11, 8'h14, 8'h15, 8'h31, 8'h32, 8'h33, 8'h00};
  wire  [7:0] rdata;
  wire        lbit, bpv, cmi_on, cmi_flip, ja_hi, ja_lo, srst, irq_n;
  wire        t_open, t_lim, t_trip;
  wire  [1:0] gain, pres;
  wire  [2:0] rxt, txt;
  wire  [3:0] t_lvl;
  int         errors = 0;
  int         n_compared = 0;
  int         i;
  logic [2:0] tc;
  always #50 mclk = ~mclk;
  lic_line_model u_line (.open_req(open_q), .lim_req(lim_q), .trip_req(trip_q),
    .level_req(lvl_q), .tx_open_in(t_open), .tx_curlim_in(t_lim),
    .ja_near_limit(t_trip), .rx_level_in(t_lvl));
  lic_line_if_regs DUT (.mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata_r(rdata), .tx_mode(mode), .tx_bit_en(ten),
    .tx_data(tdat), .rx_level_in(t_lvl), .tx_open_in(t_open), .tx_curlim_in(t_lim),
    .ja_near_limit(t_trip), .tx_line_bit(lbit), .tx_line_bpv(bpv),
    .cmi_coding_on_r(cmi_on), .cmi_polarity_flip_r(cmi_flip), .monitor_gain_r(gain),
    .rx_term_r(rxt), .tx_term_r(txt), .master_clk_prescale_r(pres),
    .ja_clk_sel_hi_r(ja_hi), .ja_clk_sel_lo_r(ja_lo), .line_if_soft_reset_r(srst),
    .irq_n_r(irq_n));
  // ==========================================================
  // Tasks
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic st;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic tx(input logic b, input logic eb, input logic ep);
    @(posedge mclk);
    ten <= 1'b1;
    tdat <= b;
    @(posedge mclk);
    ten <= 1'b0;
    #1 chk({6'h00, lbit, bpv}, {6'h00, eb, ep});
  endtask
  // Bounded wait on irq (w=0) or soft reset pulse (w=1)
  task automatic wsig(input int w, input logic e);
    int k;
    k = 0;
    while ((w ? srst : irq_n) !== e && k < 10) begin
      @(posedge mclk);
      #1 k++;
    end
    chk({7'h00, w ? srst : irq_n}, {7'h00, e});
    if (k == 10) close_out();
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    foreach (offs[k]) rd_reg(offs[k], 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    @(posedge mclk) lvl_q <= 4'hF;
    rd_reg(8'h11, 8'h0F);
    $display("reset and level test done");
    wr_reg(8'h32, 8'hFF);
    rd_reg(8'h32, `LIC_C_WMASK);
    st();
    chk({cmi_on, cmi_flip, 4'h0, gain}, 8'hC3);
    wr_reg(8'h15, 8'hFF);
    rd_reg(8'h15, `LIC_S_WMASK);
    for (i = 0; i < 8; i++) begin
      tc = 3'h7 - i[2:0];
      wr_reg(8'h33, {i[1:0], tc, i[2:0]});
      st();
      chk({pres, rxt, txt}, {i[1:0], (i>4) ? 3'h0 : i[2:0], (i<3) ? 3'h0 : tc});
    end
    wr_reg(8'h31, 8'h98);
    st();
    chk({6'h00, ja_hi, ja_lo}, 8'h03);
    wr_reg(8'h31, 8'hD8);
    wsig(1, 1'b1);
    wr_reg(8'h31, 8'h98);
    $display("control test done");
    wr_reg(8'h32, 8'h01);
    tx(1, 0, 0);
    tx(1, 1, 0);
    tx(1, 0, 0);
    wr_reg(8'h32, 8'h00);
    st();
    chk({cmi_on, cmi_flip, 4'h0, gain}, 8'h00);
    tx(0, 0, 0);
    wr_reg(8'h31, 8'hB8);
    tx(0, 0, 0);
    tx(1, 1, 0);
    tx(1, 1, 0);
    tx(1, 1, 1);
    repeat (3) tx(1, 1, 0);
    wr_reg(8'h31, 8'h88);
    tx(0, 1, 0);
    @(posedge mclk) mode <= 2'h1;
    wr_reg(8'h31, 8'h98);
    wr_reg(8'h31, 8'hB8);
    repeat (3) tx(1, 1, 0);
    @(posedge mclk) mode <= 2'h0;
    $display("transmit test done");
    @(posedge mclk) open_q <= 1'b1;
    wsig(0, 1'b0);
    rd_reg(8'h14, 8'h02);
    wsig(0, 1'b1);
    @(posedge mclk) open_q <= 1'b0;
    wsig(0, 1'b0);
    rd_reg(8'h14, 8'h00);
    wsig(0, 1'b1);
    @(posedge mclk) trip_q <= 1'b1;
    @(posedge mclk) trip_q <= 1'b0;
    wsig(0, 1'b0);
    rd_reg(8'h14, 8'h10);
    rd_reg(8'h14, 8'h00);
    wr_reg(8'h15, 8'h00);
    @(posedge mclk) lim_q <= 1'b1;
    trip_q <= 1'b1;
    @(posedge mclk) trip_q <= 1'b0;
    st();
    st();
    chk({7'h00, irq_n}, 8'h01);
    rd_reg(8'h14, 8'h14);
    wr_reg(8'h32, 8'h80);
    st();
    rd_reg(8'h14, 8'h00);
    wr_reg(8'h32, 8'h00);
    @(posedge mclk) mode <= 2'h2;
    open_q <= 1'b1;
    st();
    rd_reg(8'h14, 8'h00);
    $display("status test done");
    close_out();
  end
endmodule // lic_line_if_regs_tb
`default_nettype wire

/* test/lic_line_model.sv */
// Purpose: line side model feeding the detector levels
// Assumes: the bench changes requests just after a rising edge
// Notes:   no analog timing; levels follow requests at once
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Line side model
module lic_line_model (
  input  wire logic       open_req,
  input  wire logic       lim_req,
  input  wire logic       trip_req,
  input  wire logic [3:0] level_req,
  output wire logic       tx_open_in,
  output wire logic       tx_curlim_in,
  output wire logic       ja_near_limit,
  output wire logic [3:0] rx_level_in
);
  // Plain levels: a real detector would also chatter near threshold
  assign tx_open_in    = open_req;
  assign tx_curlim_in  = lim_req;
  assign ja_near_limit = trip_req;
  assign rx_level_in   = level_req;
endmodule // lic_line_model
`default_nettype wire
